// file: cam_position_restore.sv
// cam start restore selection with its register file
`timescale 1ns/1ps
`include "cam_restore_defines.svh"
module cam_position_restore #(
    parameter int POS_W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [`CR_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // cam control events
    input wire logic cam_start,
    input wire logic cam_stop,
    // live axis positions
    input wire logic signed [POS_W-1:0] feed_pos,
    input wire logic signed [POS_W-1:0] input_cycle_pos,
    input wire logic [POS_W-1:0] cam_cycle_end_pos,
    // restored positions
    output logic [POS_W-1:0] main_cycle_pos,
    output logic signed [POS_W-1:0] cam_base_pos,
    output logic [POS_W-1:0] cam_cycle_pos,
    output logic signed [POS_W-1:0] cam_feed_pos,
    output logic [1:0] cycle_pos_unit,
    output logic restore_done,
    output logic cam_active
);
    localparam int SW = `CR_SEL_W;

    typedef struct packed {
        cam_restore_pkg::phase_e phase;
        // software settings
        logic [SW-1:0] main_method;
        logic [SW-1:0] target;
        logic [SW-1:0] base_method;
        logic [SW-1:0] cycle_method;
        logic signed [POS_W-1:0] main_init;
        logic signed [POS_W-1:0] base_init;
        logic signed [POS_W-1:0] search_start;
        logic [SW-1:0] enc_unit;
        logic [SW-1:0] input_axis;
        logic [POS_W-1:0] cycle_len;
        logic [SW-1:0] out_unit;
        // copies taken at cam start
        logic [SW-1:0] sh_main_method;
        logic [SW-1:0] sh_target;
        logic [SW-1:0] sh_base_method;
        logic [SW-1:0] sh_cycle_method;
        logic signed [POS_W-1:0] sh_main_init;
        logic signed [POS_W-1:0] sh_base_init;
        logic signed [POS_W-1:0] sh_search_start;
        logic [SW-1:0] sh_input_axis;
        logic [POS_W-1:0] sh_cycle_len;
        logic signed [POS_W-1:0] sh_feed;
        logic signed [POS_W-1:0] sh_input;
        // results and status
        logic [POS_W-1:0] main_pos;
        logic signed [POS_W-1:0] base_pos;
        logic [POS_W-1:0] cycle_pos;
        logic signed [POS_W-1:0] feed;
        logic [1:0] unit;
        logic base_ok;
        logic err_main;
        logic err_base;
        logic err_search;
        logic done;
        logic active;
        logic [31:0] rdata;
    } ctrl_s;

    ctrl_s s;
    ctrl_s next_s;

    // ==========================================================
    // cycle window checks
    // ==========================================================
    logic signed [POS_W-1:0] win_val [3];
    logic win_ok [3];
    logic [POS_W-1:0] win_wrap [3];

    assign win_val[0] = s.sh_main_init;
    assign win_val[1] = s.sh_search_start;
    assign win_val[2] = s.sh_input;

    for (genvar i = 0; i < 3; i++) begin : g_win
        cycle_window #(
            .POS_W(POS_W)
        ) u_win (
            .value(win_val[i]),
            .cycle_len(s.sh_cycle_len),
            .in_range(win_ok[i]),
            .wrapped(win_wrap[i])
        );
    end

    // ==========================================================
    // previous values
    // ==========================================================
    logic signed [POS_W-1:0] prev_base;
    logic [POS_W-1:0] prev_cycle;
    logic prev_valid;
    logic save_prev;

    assign save_prev = (s.phase == cam_restore_pkg::ST_RUN) && cam_stop;

    prev_store #(
        .POS_W(POS_W)
    ) u_prev (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .save(save_prev),
        .base_saved(s.base_ok),
        .base_in(s.base_pos),
        .feed_in(feed_pos),
        .cycle_in(cam_cycle_end_pos),
        .prev_base(prev_base),
        .prev_cycle(prev_cycle),
        .prev_valid(prev_valid)
    );

    // ==========================================================
    // next state
    // ==========================================================
    logic [POS_W-1:0] sel_main;
    logic signed [POS_W-1:0] base_lim;
    logic [31:0] status;

    assign base_lim = POS_W'(`CR_BASE_LIMIT);
    assign status = {16'h0000, 6'h00, s.unit, 2'h0,
                     s.phase != cam_restore_pkg::ST_IDLE,
                     s.err_search, s.err_base, s.err_main, prev_valid, prev_valid};

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.rdata = 32'h00000000;
        sel_main = s.main_pos;

        // register writes land at any time, only the copies drive a restore
        if (reg_wr) begin
            case (reg_addr)
                `CR_OFS_MAIN_METHOD: next_s.main_method = reg_wdata[SW-1:0];
                `CR_OFS_TARGET: next_s.target = reg_wdata[SW-1:0];
                `CR_OFS_BASE_METHOD: next_s.base_method = reg_wdata[SW-1:0];
                `CR_OFS_CYCLE_METHOD: next_s.cycle_method = reg_wdata[SW-1:0];
                `CR_OFS_MAIN_INIT: next_s.main_init = POS_W'(reg_wdata);
                `CR_OFS_BASE_INIT: next_s.base_init = POS_W'(reg_wdata);
                `CR_OFS_SEARCH_START: next_s.search_start = POS_W'(reg_wdata);
                `CR_OFS_ENC_UNIT: next_s.enc_unit = reg_wdata[SW-1:0];
                `CR_OFS_INPUT_AXIS: next_s.input_axis = reg_wdata[SW-1:0];
                `CR_OFS_CYCLE_LEN: next_s.cycle_len = POS_W'(reg_wdata);
                `CR_OFS_OUT_UNIT: next_s.out_unit = reg_wdata[SW-1:0];
                default: ;
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                `CR_OFS_MAIN_METHOD: next_s.rdata = 32'(s.main_method);
                `CR_OFS_TARGET: next_s.rdata = 32'(s.target);
                `CR_OFS_BASE_METHOD: next_s.rdata = 32'(s.base_method);
                `CR_OFS_CYCLE_METHOD: next_s.rdata = 32'(s.cycle_method);
                `CR_OFS_MAIN_INIT: next_s.rdata = 32'(s.main_init);
                `CR_OFS_BASE_INIT: next_s.rdata = 32'(s.base_init);
                `CR_OFS_SEARCH_START: next_s.rdata = 32'(s.search_start);
                `CR_OFS_ENC_UNIT: next_s.rdata = 32'(s.enc_unit);
                `CR_OFS_INPUT_AXIS: next_s.rdata = 32'(s.input_axis);
                `CR_OFS_CYCLE_LEN: next_s.rdata = 32'(s.cycle_len);
                `CR_OFS_OUT_UNIT: next_s.rdata = 32'(s.out_unit);
                `CR_OFS_STATUS: next_s.rdata = status;
                `CR_OFS_MAIN_POS: next_s.rdata = 32'(s.main_pos);
                `CR_OFS_BASE_POS: next_s.rdata = 32'(s.base_pos);
                `CR_OFS_CYCLE_POS: next_s.rdata = 32'(s.cycle_pos);
                `CR_OFS_FEED_POS: next_s.rdata = 32'(s.feed);
                default: next_s.rdata = 32'h00000000;
            endcase
        end

        case (s.phase)
            cam_restore_pkg::ST_IDLE: begin
                if (cam_start) begin
                    next_s.phase = cam_restore_pkg::ST_LATCH;
                end
            end
            cam_restore_pkg::ST_LATCH: begin
                // settings are frozen here and nowhere else
                next_s.sh_main_method = s.main_method;
                next_s.sh_target = s.target;
                next_s.sh_base_method = s.base_method;
                next_s.sh_cycle_method = s.cycle_method;
                next_s.sh_main_init = s.main_init;
                next_s.sh_base_init = s.base_init;
                next_s.sh_search_start = s.search_start;
                next_s.sh_input_axis = s.input_axis;
                next_s.sh_cycle_len = s.cycle_len;
                next_s.sh_feed = feed_pos;
                next_s.sh_input = input_cycle_pos;
                // unit of the one-cycle values follows the main input axis
                case (s.input_axis)
                    cam_restore_pkg::AXIS_SERVO: next_s.unit = s.out_unit;
                    cam_restore_pkg::AXIS_ENCODER: next_s.unit = s.enc_unit;
                    default: next_s.unit = s.unit;
                endcase
                next_s.phase = cam_restore_pkg::ST_SELECT;
            end
            cam_restore_pkg::ST_SELECT: begin
                // one pass: main, then base, then cam cycle from the fresh main
                next_s.err_main = 1'b0;
                next_s.err_base = 1'b0;
                next_s.err_search = 1'b0;
                case (s.sh_main_method)
                    2'h0: sel_main = s.main_pos;
                    2'h1: begin
                        sel_main = win_ok[0] ? $unsigned(s.sh_main_init) : '0;
                        next_s.err_main = !win_ok[0];
                    end
                    2'h2: begin
                        // a disabled input axis gives no position to derive from
                        sel_main = (s.sh_input_axis == cam_restore_pkg::AXIS_OFF) ?
                                   '0 : win_wrap[2];
                    end
                    default: sel_main = s.main_pos;
                endcase
                next_s.main_pos = sel_main;

                next_s.base_ok = 1'b1;
                case (s.sh_base_method)
                    2'h0: next_s.base_pos = s.sh_feed;
                    2'h1: begin
                        if (s.sh_base_init > base_lim || s.sh_base_init < -base_lim) begin
                            next_s.base_pos = s.sh_feed;
                            next_s.err_base = 1'b1;
                            next_s.base_ok = 1'b0;
                        end else begin
                            next_s.base_pos = s.sh_base_init;
                        end
                    end
                    2'h2: next_s.base_pos = prev_valid ? prev_base : s.sh_feed;
                    default: next_s.base_pos = s.sh_feed;
                endcase

                if (s.sh_target == cam_restore_pkg::TGT_CYCLE) begin
                    // search begins at the start point, return path included
                    next_s.cycle_pos = win_ok[1] ? $unsigned(s.sh_search_start) : '0;
                    next_s.err_search = !win_ok[1];
                end else begin
                    case (s.sh_cycle_method)
                        2'h0: next_s.cycle_pos = prev_valid ? prev_cycle : '0;
                        2'h1: begin
                            next_s.cycle_pos = win_ok[1] ? $unsigned(s.sh_search_start) : '0;
                            next_s.err_search = !win_ok[1];
                        end
                        2'h2: next_s.cycle_pos = sel_main;
                        default: next_s.cycle_pos = '0;
                    endcase
                end
                next_s.feed = s.sh_feed;
                next_s.done = 1'b1;
                next_s.phase = cam_restore_pkg::ST_RUN;
            end
            cam_restore_pkg::ST_RUN: begin
                if (cam_stop) begin
                    next_s.phase = cam_restore_pkg::ST_IDLE;
                end
            end
            default: next_s.phase = cam_restore_pkg::ST_IDLE;
        endcase
        // registered copy of the run phase, so the pin carries no decode
        next_s.active = (next_s.phase == cam_restore_pkg::ST_RUN);
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign main_cycle_pos = s.main_pos;
    assign cam_base_pos = s.base_pos;
    assign cam_cycle_pos = s.cycle_pos;
    assign cam_feed_pos = s.feed;
    assign cycle_pos_unit = s.unit;
    assign restore_done = s.done;
    assign cam_active = s.active;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_one_pass_done: assert property ((s.phase == cam_restore_pkg::ST_IDLE) && cam_start
        |=> ##2 restore_done ##1 !restore_done && cam_active)
        else $error("restore not finished in one pass");
    a_main_init_pick: assert property (restore_done && s.sh_main_method == 2'h1 && !s.err_main
        |-> main_cycle_pos == $unsigned(s.sh_main_init))
        else $error("main one-cycle position not the initial value");
    a_main_init_range: assert property (restore_done && s.sh_main_method == 2'h1
        |-> main_cycle_pos < s.sh_cycle_len || s.sh_cycle_len == '0)
        else $error("main one-cycle position outside the cycle");
    a_base_feed_pick: assert property (restore_done && s.sh_base_method == 2'h0
        |-> cam_base_pos == s.sh_feed)
        else $error("cam standard position not the feed position");
    a_base_limit: assert property (restore_done && s.sh_base_method == 2'h1 && !s.err_base
        |-> cam_base_pos <= base_lim && cam_base_pos >= -base_lim)
        else $error("cam standard position beyond limit");
    a_cycle_from_main: assert property (restore_done && s.sh_target != 2'h0
        && s.sh_cycle_method == 2'h2 |-> cam_cycle_pos == main_cycle_pos)
        else $error("cam cycle position not the main position");
    a_search_start: assert property (restore_done && s.sh_target == 2'h0 && !s.err_search
        |-> cam_cycle_pos == $unsigned(s.sh_search_start))
        else $error("restore search start not used");
    a_len_frozen: assert property (cam_active && !cam_stop
        |=> s.sh_cycle_len == $past(s.sh_cycle_len))
        else $error("cycle length changed while running");
    a_read_next: assert property (reg_rd && reg_addr == `CR_OFS_CYCLE_LEN
        |=> reg_rdata == 32'($past(s.cycle_len)))
        else $error("cycle length read back wrong");
endmodule : cam_position_restore

// file: cam_restore_defines.svh
// register offsets, field positions, reset values and limits of the cam restore block
// How it works
// - The main axis one-cycle position at cam start comes from the previous value (0), the initial value (1) or the input axis (2).
// - The restore target selects the cam axis one-cycle position (0), the cam standard position (1) or the feed position (2).
// - The cam standard position comes from the current feed position (0), the initial value (1) or the stored previous value (2).
// - The cam standard position of the last cam control is kept as previous value, or the feed position when none was saved.
// - Reset at power-up clears both stored previous values so no history survives.
// - For targets 1 and 2 the cam one-cycle position comes from the previous value (0), the initial value (1) or the main one-cycle position (2).
// - The cam one-cycle position at the end of the last cam control is kept as previous value.
// - The initial main one-cycle position is accepted only from zero to one below the cycle length.
// - One-cycle initial values use the output axis unit with input axis 1 and the encoder axis unit with input axis 2.
// - The initial cam standard position is used only with method 1 and is accepted only within -999999 to 999999; beyond that the feed position is used.
// - The search for the restored cam one-cycle position starts at a point from zero to one below the cycle length.
// - The encoder axis unit is one digit: 0 mm, 1 inch, 2 degree, 3 pulse.
// - The main input axis selection means 0 disabled, 1 servo input axis, 2 encoder axis.
// - Cycle length and the other cam settings are taken over only when cam control starts.
`ifndef CAM_RESTORE_DEFINES_SVH
`define CAM_RESTORE_DEFINES_SVH

`define CR_ADDR_W 12
`define CR_OFS_MAIN_METHOD 12'h004
`define CR_OFS_TARGET 12'h008
`define CR_OFS_BASE_METHOD 12'h00C
`define CR_OFS_CYCLE_METHOD 12'h010
`define CR_OFS_MAIN_INIT 12'h014
`define CR_OFS_BASE_INIT 12'h018
`define CR_OFS_SEARCH_START 12'h01C
`define CR_OFS_ENC_UNIT 12'h038
`define CR_OFS_INPUT_AXIS 12'h078
`define CR_OFS_CYCLE_LEN 12'h0C0
`define CR_OFS_OUT_UNIT 12'h100
`define CR_OFS_STATUS 12'h108
`define CR_OFS_MAIN_POS 12'h10C
`define CR_OFS_BASE_POS 12'h110
`define CR_OFS_CYCLE_POS 12'h114
`define CR_OFS_FEED_POS 12'h118

`define CR_SEL_W 2
`define CR_SEL_RESET 2'h0
`define CR_BASE_LIMIT 32'h000F423F

`define CR_ST_PREV_BASE 0
`define CR_ST_PREV_CYCLE 1
`define CR_ST_ERR_MAIN 2
`define CR_ST_ERR_BASE 3
`define CR_ST_ERR_SEARCH 4
`define CR_ST_ACTIVE 5
`define CR_ST_UNIT_LSB 8

`endif

// file: cam_restore_pkg.sv
// types shared by the cam restore block
package cam_restore_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LATCH = 2'b01,
        ST_SELECT = 2'b10,
        ST_RUN = 2'b11
    } phase_e;

    typedef enum logic [1:0] {
        AXIS_OFF = 2'b00,
        AXIS_SERVO = 2'b01,
        AXIS_ENCODER = 2'b10
    } input_axis_e;

    typedef enum logic [1:0] {
        TGT_CYCLE = 2'b00,
        TGT_BASE = 2'b01,
        TGT_FEED = 2'b10
    } restore_target_e;
endpackage : cam_restore_pkg

// file: cycle_window.sv
// range check and single-step wrap of a position against the cam cycle length
`timescale 1ns/1ps
module cycle_window #(
    parameter int POS_W = 32
) (
    // position and cycle
    input wire logic signed [POS_W-1:0] value,
    input wire logic [POS_W-1:0] cycle_len,
    // results
    output logic in_range,
    output logic [POS_W-1:0] wrapped
);
    // zero length leaves no position legal
    assign in_range = (value >= 0) && ($unsigned(value) < cycle_len);
    // one step is enough for input positions already near the cycle
    assign wrapped = (value < 0) ? $unsigned(value) + cycle_len :
                     (in_range || cycle_len == '0) ? $unsigned(value) :
                     $unsigned(value) - cycle_len;
endmodule : cycle_window

// file: prev_store.sv
// previous cam standard and cam one-cycle positions kept across cam controls
`timescale 1ns/1ps
module prev_store #(
    parameter int POS_W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // end of cam control
    input wire logic save,
    input wire logic base_saved,
    input wire logic signed [POS_W-1:0] base_in,
    input wire logic signed [POS_W-1:0] feed_in,
    input wire logic [POS_W-1:0] cycle_in,
    // stored values
    output logic signed [POS_W-1:0] prev_base,
    output logic [POS_W-1:0] prev_cycle,
    output logic prev_valid
);
    typedef struct packed {
        logic signed [POS_W-1:0] base;
        logic [POS_W-1:0] cycle;
        logic valid;
    } store_s;

    store_s s;
    store_s next_s;

    always_comb begin
        next_s = s;
        if (save) begin
            next_s.base = base_saved ? base_in : feed_in;
            next_s.cycle = cycle_in;
            next_s.valid = 1'b1;
        end
    end

    // power-up reset is the only thing that clears history
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prev_base = s.base;
    assign prev_cycle = s.cycle;
    assign prev_valid = s.valid;

    a_save_keeps_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        save |=> (prev_cycle == $past(cycle_in)) && prev_valid)
        else $error("previous cam cycle position not stored");
endmodule : prev_store

// file: cam_position_restore_test.sv
// random regression of the cam start restore block
`timescale 1ns/1ps
`include "cam_restore_defines.svh"
module cam_position_restore_test;
    // ====================
    // clock, reset and register port
    logic clk_sys;
    logic arst_n;
    logic [`CR_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    // cam events and positions
    logic cam_start;
    logic cam_stop;
    logic signed [31:0] feed_pos;
    logic signed [31:0] input_cycle_pos;
    logic [31:0] cam_cycle_end_pos;
    logic [31:0] main_cycle_pos;
    logic signed [31:0] cam_base_pos;
    logic [31:0] cam_cycle_pos;
    logic signed [31:0] cam_feed_pos;
    logic [1:0] cycle_pos_unit;
    logic restore_done;
    logic cam_active;
    // bench-side counters and history; only the history is cleared with every reset
    int n_fail;
    int checks_done;
    int cycles;
    logic [31:0] rnd;
    logic [31:0] prev_main;
    logic [31:0] prev_cycle;
    logic signed [31:0] prev_base;
    logic base_hist;
    logic cycle_hist;
    logic [1:0] unit;

    cam_position_restore #(.POS_W(32)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_start(cam_start),
        .cam_stop(cam_stop), .feed_pos(feed_pos), .input_cycle_pos(input_cycle_pos),
        .cam_cycle_end_pos(cam_cycle_end_pos), .main_cycle_pos(main_cycle_pos),
        .cam_base_pos(cam_base_pos), .cam_cycle_pos(cam_cycle_pos), .cam_feed_pos(cam_feed_pos),
        .cycle_pos_unit(cycle_pos_unit), .restore_done(restore_done), .cam_active(cam_active)
    );

    // ====================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // boundary values of a one-cycle setting are drawn half the time
    function automatic logic [31:0] pick(input logic [31:0] r, input logic [31:0] len);
        case (r[1:0])
            2'h0: pick = len;
            2'h1: pick = len - 32'h1;
            2'h2: pick = len + {28'h0, r[7:4]};
            default: pick = {8'h00, r[31:8]} % len;
        endcase
    endfunction : pick
    function automatic logic [31:0] wrap(input logic [31:0] v, input logic [31:0] len);
        wrap = (v >= len) ? v - len : v;
    endfunction : wrap
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check
    task automatic reg_write(input logic [`CR_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [`CR_ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        {prev_main, prev_cycle, prev_base, base_hist, cycle_hist, unit} = '0;
    endtask : do_reset

    // ====================
    // one cam control: settings, start, compare, stop
    task automatic run_case(input logic [1:0] mm, input logic [1:0] tgt, input logic [1:0] bm,
                            input logic [1:0] cm, input logic [1:0] ax);
        logic [31:0] len;
        logic [31:0] mi;
        logic [31:0] si;
        logic [31:0] w_main;
        logic [31:0] w_cyc;
        logic [31:0] got;
        logic signed [31:0] bi;
        logic signed [31:0] w_base;
        int i;
        rnd = lfsr(rnd);
        len = 32'h10 + {22'h0, rnd[9:0]};
        mi = pick(rnd, len);
        rnd = lfsr(rnd);
        si = pick(rnd, len);
        rnd = lfsr(rnd);
        case (rnd[5:4])
            2'h0: bi = 32'h000F423F;
            2'h1: bi = 32'h000F4240;
            2'h2: bi = 32'hFFF0BDC1;
            default: bi = {12'h000, rnd[31:12]};
        endcase
        reg_write(`CR_OFS_CYCLE_LEN, len);
        reg_write(`CR_OFS_MAIN_METHOD, {30'h0, mm});
        reg_write(`CR_OFS_TARGET, {30'h0, tgt});
        reg_write(`CR_OFS_BASE_METHOD, {30'h0, bm});
        reg_write(`CR_OFS_CYCLE_METHOD, {30'h0, cm});
        reg_write(`CR_OFS_INPUT_AXIS, {30'h0, ax});
        reg_write(`CR_OFS_MAIN_INIT, mi);
        reg_write(`CR_OFS_BASE_INIT, bi);
        reg_write(`CR_OFS_SEARCH_START, si);
        reg_write(`CR_OFS_ENC_UNIT, {30'h0, rnd[1:0]});
        reg_write(`CR_OFS_OUT_UNIT, {30'h0, rnd[3:2]});
        // feed stays put across the whole control so the saved base is unambiguous
        feed_pos <= lfsr(rnd);
        input_cycle_pos <= rnd % (len * 32'h2);
        cam_cycle_end_pos <= {rnd[15:0], rnd[31:16]};
        cam_start <= 1'b1;
        @(posedge clk_sys);
        cam_start <= 1'b0;
        #1;
        for (i = 0; i < 6 && restore_done !== 1'b1; i++) @(posedge clk_sys) #1;
        unit = (ax == 2'h1) ? rnd[3:2] : (ax == 2'h2) ? rnd[1:0] : unit;
        w_main = (mm == 2'h0) ? prev_main : (mm == 2'h1) ? ((mi < len) ? mi : 32'h0)
               : (ax == 2'h0) ? 32'h0 : wrap(input_cycle_pos, len);
        si = (si < len) ? si : 32'h0;
        w_cyc = (tgt == 2'h0 || cm == 2'h1) ? si
              : (cm == 2'h0) ? (cycle_hist ? prev_cycle : 32'h0) : w_main;
        w_base = (bm == 2'h2 && base_hist) ? prev_base
               : (bm == 2'h1 && bi <= 999999 && bi >= -999999) ? bi : feed_pos;
        check({31'h0, restore_done}, 32'h1, "done");
        check({31'h0, cam_active}, 32'h1, "active");
        check(main_cycle_pos, w_main, "main");
        check(cam_base_pos, w_base, "base");
        check(cam_cycle_pos, w_cyc, "cycle");
        check(cam_feed_pos, feed_pos, "feed");
        check({30'h0, cycle_pos_unit}, {30'h0, unit}, "unit");
        reg_read(`CR_OFS_MAIN_POS, got);
        check(got, w_main, "main reg");
        // settings changed in mid-run and a repeated start must not disturb the result
        reg_write(`CR_OFS_MAIN_INIT, 32'h0);
        cam_start <= 1'b1;
        reg_write(`CR_OFS_MAIN_METHOD, 32'h1);
        cam_start <= 1'b0;
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys) #1;
            check({31'h0, restore_done}, 32'h0, "restart");
            check(main_cycle_pos, w_main, "held");
        end
        @(posedge clk_sys);
        cam_stop <= 1'b1;
        @(posedge clk_sys);
        cam_stop <= 1'b0;
        #1;
        for (i = 0; i < 6 && cam_active !== 1'b0; i++) @(posedge clk_sys) #1;
        check({31'h0, cam_active}, 32'h0, "stop");
        {prev_main, prev_base, prev_cycle} = {w_main, w_base, cam_cycle_end_pos};
        {base_hist, cycle_hist} = 2'b11;
    endtask : run_case

    // ====================
    // clock, timeout and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin : main_seq
        logic [31:0] got;
        {reg_addr, reg_wdata, reg_wr, reg_rd, cam_start, cam_stop} = '0;
        {feed_pos, input_cycle_pos, cam_cycle_end_pos} = '0;
        {n_fail, checks_done, cycles} = '0;
        rnd = 32'h000101DD;
        do_reset();
        #1;
        check(main_cycle_pos, 32'h0, "reset main");
        check(cam_cycle_pos, 32'h0, "reset cycle");
        reg_read(`CR_OFS_STATUS, got);
        check(got, 32'h0, "status");
        reg_read(12'h0FC, got);
        check(got, 32'h0, "unmapped");
        run_case(2'h0, 2'h1, 2'h2, 2'h0, 2'h2);
        run_case(2'h2, 2'h2, 2'h2, 2'h0, 2'h1);
        for (int k = 0; k < 36; k++) begin
            rnd = lfsr(rnd);
            run_case(rnd[1:0] % 2'h3, rnd[3:2] % 2'h3, rnd[5:4] % 2'h3, rnd[7:6] % 2'h3,
                     rnd[9:8] % 2'h3);
        end
        do_reset();
        run_case(2'h0, 2'h2, 2'h2, 2'h0, 2'h0);
        tally_and_finish();
    end
endmodule : cam_position_restore_test
